/* pkg/charger_cfg_map.vh */
// register map, field positions and reset values of the three charger configuration registers
// included by the register bank and its thermal profile helper
`ifndef CHARGER_CFG_MAP_VH
`define CHARGER_CFG_MAP_VH

`define CFG_SIX_ADDR      8'h1c
`define CFG_SEVEN_ADDR    8'h1d
`define CFG_EIGHT_ADDR    8'h1e
`define CFG_SIX_RST       8'h00
`define CFG_SEVEN_RST     8'h32
`define CFG_EIGHT_RST     8'h15
`define CC_CODE_RST       8'h00
`define COMMIT_BIT        7
`define RSVD_BIT          6
`define PFM_HI            5
`define PFM_LO            4
`define KEY_HI            3
`define KEY_LO            2
`define KICK_HI           1
`define KICK_LO           0
`define KEY_OPEN          2'h3
`define KICK_CODE         2'h3
`define PFM_20K           2'h0
`define PFM_OFF           2'h3
`define PROFILE_BIT       7
`define SETPOINT_HI       6
`define SETPOINT_LO       3
`define SETPOINT_MAX      4'h9
`define SETPOINT_BASE_C   8'd85
`define SETPOINT_STEP_C   8'd5
`define COOL_V_BIT        2
`define COOL_I_BIT        1
`define STORAGE_BIT       0
`define TOP_BIT           7

`endif

/* verilog/thermal_profile.v */
// temperature profile: derives effective current code, voltage reduction and foldback from settings
// assumes temperature inputs are already synchronous to core_clk
`timescale 1ns/1ps
`include "charger_cfg_map.vh"

module thermal_profile (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // settings
  input  wire       temp_profile_enable,
  input  wire [3:0] junction_regulation_setpoint,
  input  wire       cool_zone_voltage_reduce,
  input  wire       cool_zone_current_halve,
  input  wire [8:0] active_current_code,
  // sensed conditions
  input  wire [7:0] junction_temp_c,
  input  wire       in_cool_zone,
  // results
  output reg  [8:0] effective_current_code,
  output reg        termination_voltage_reduce,
  output reg        thermal_foldback_flag
);

  //////////////////////////////////////////////////////////////////////////////
  // setpoint in degrees; codes above the top step clamp to it
  function [7:0] setpoint_c;
    input [3:0] code;
    reg   [3:0] c;
    begin
      c = (code > `SETPOINT_MAX) ? `SETPOINT_MAX : code;
      setpoint_c = `SETPOINT_BASE_C + `SETPOINT_STEP_C * {4'h0, c};
    end
  endfunction

  wire cool_active = temp_profile_enable & in_cool_zone;

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      effective_current_code     <= 9'h000;
      termination_voltage_reduce <= 1'b0;
      thermal_foldback_flag      <= 1'b0;
    end else begin
      // foldback of the current limit itself belongs to the analog loop fed by this flag
      thermal_foldback_flag      <= (junction_temp_c > setpoint_c(junction_regulation_setpoint));
      termination_voltage_reduce <= cool_active & cool_zone_voltage_reduce;
      if (cool_active && cool_zone_current_halve)
        effective_current_code <= {1'b0, active_current_code[8:1]};
      else
        effective_current_code <= active_current_code;
    end
  end

endmodule // thermal_profile

/* verilog/charger_config_regs.v */
// register bank for charger configuration six, seven and eight, with staged current code commit
// assumes the serial interface delivers one-cycle write strobes and a combinational read address
// How it works
// - bit7 write commits staged current, then clears
// - current top bit staged separately, commit only
// - pfm field: 0 is 20kHz, 3 disables
// - key 3 unlocks protected registers
// - other key codes lock; reset locked
// - kick code 3 restarts watchdog if enabled
// - profile enable lets temperature change settings
// - setpoint code 0 is 85C, +5C steps
// - over setpoint sets foldback flag
// - cool zone lowers termination voltage 180mV/cell
// - cool zone halves fast charge current
`timescale 1ns/1ps
`include "charger_cfg_map.vh"

module charger_config_regs (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // serial register interface
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  output reg  [7:0] reg_rdata,
  // staged low current code, its protection and the watchdog enable
  input  wire [7:0] fast_charge_current_code,
  input  wire       watchdog_enabled,
  input  wire       cc_reg_protected,
  // sensed conditions
  input  wire [7:0] junction_temp_c,
  input  wire       in_cool_zone,
  // outputs to the charger
  output reg  [8:0] active_current_code,
  output wire [8:0] effective_current_code,
  output wire       termination_voltage_reduce,
  output wire       thermal_foldback_flag,
  output wire [1:0] pulse_skip_floor_freq,
  output wire       pulse_skip_floor_disable,
  output wire       settings_unlocked,
  output reg        watchdog_restart,
  output reg        charge_current_commit,
  output wire       temp_profile_enable,
  output wire       forced_storage_mode
);

  //////////////////////////////////////////////////////////////////////////////
  // stored registers and their next values
  reg  [7:0] six_r;
  reg  [7:0] six_nxt;
  reg  [7:0] seven_r;
  wire [7:0] seven_nxt;
  reg  [7:0] eight_r;
  wire [7:0] eight_nxt;
  reg        unlocked_r;
  reg        unlocked_nxt;
  reg  [8:0] active_nxt;
  reg        restart_nxt;
  reg        commit_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // address match, shared by the write decode and the read path
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // a two-bit code field counts only on its exact value
  function code_is;
    input [1:0] field;
    input [1:0] code;
    begin
      code_is = (field == code);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // write decode
  wire       wr_six     = reg_wr && addr_is(reg_addr, `CFG_SIX_ADDR);
  wire       wr_seven   = reg_wr && addr_is(reg_addr, `CFG_SEVEN_ADDR);
  wire       wr_eight   = reg_wr && addr_is(reg_addr, `CFG_EIGHT_ADDR);
  wire       key_ok     = code_is(reg_wdata[`KEY_HI:`KEY_LO], `KEY_OPEN);
  wire       kick_ok    = code_is(reg_wdata[`KICK_HI:`KICK_LO], `KICK_CODE);
  wire       commit_req = wr_six && reg_wdata[`COMMIT_BIT];
  // the low code register lives outside; its protection is steered here
  wire       cc_allowed = !cc_reg_protected || unlocked_r;

  //////////////////////////////////////////////////////////////////////////////
  // plain storage bits: seven takes every write, eight only when allowed
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_store_bit
      assign seven_nxt[g] = wr_seven ? reg_wdata[g] : seven_r[g];
      // a refused write leaves the top bit and the limit bits as they were
      assign eight_nxt[g] = (wr_eight && cc_allowed) ? reg_wdata[g] : eight_r[g];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // configuration six: command, floor, key and kick fields
  always @* begin
    six_nxt = six_r;
    if (wr_six) begin
      // commit bit never stores: it reads back zero, acting as an auto-clear
      six_nxt[`COMMIT_BIT]       = 1'b0;
      // reserved bit stored as written; the host keeps it at zero
      six_nxt[`RSVD_BIT]         = reg_wdata[`RSVD_BIT];
      six_nxt[`PFM_HI:`PFM_LO]   = reg_wdata[`PFM_HI:`PFM_LO];
      six_nxt[`KEY_HI:`KEY_LO]   = reg_wdata[`KEY_HI:`KEY_LO];
      six_nxt[`KICK_HI:`KICK_LO] = reg_wdata[`KICK_HI:`KICK_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // settings key
  always @* begin
    unlocked_nxt = unlocked_r;
    if (wr_six) begin
      // every write to six relatches the key, so any other code relocks
      unlocked_nxt = key_ok;
    end
  end

  // kick only counts with the watchdog running
  always @* begin
    restart_nxt = 1'b0;
    if (wr_six && kick_ok && watchdog_enabled) begin
      restart_nxt = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // current commit; the lock is judged before this same write's key lands
  always @* begin
    active_nxt = active_current_code;
    commit_nxt = 1'b0;
    if (commit_req && cc_allowed) begin
      active_nxt = {eight_r[`TOP_BIT], fast_charge_current_code};
      commit_nxt = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register state
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      six_r      <= `CFG_SIX_RST;
      seven_r    <= `CFG_SEVEN_RST;
      eight_r    <= `CFG_EIGHT_RST;
      unlocked_r <= 1'b0;
    end else begin
      six_r      <= six_nxt;
      seven_r    <= seven_nxt;
      eight_r    <= eight_nxt;
      unlocked_r <= unlocked_nxt;
    end
  end

  // active code and the one-cycle pulses
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_current_code   <= {1'b0, `CC_CODE_RST};
      watchdog_restart      <= 1'b0;
      charge_current_commit <= 1'b0;
    end else begin
      active_current_code   <= active_nxt;
      watchdog_restart      <= restart_nxt;
      charge_current_commit <= commit_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path: combinational, unmapped addresses read zero
  always @* begin
    reg_rdata = 8'h00;
    if (addr_is(reg_addr, `CFG_SIX_ADDR)) begin
      reg_rdata = six_r;
    end
    if (addr_is(reg_addr, `CFG_SEVEN_ADDR)) begin
      reg_rdata = seven_r;
    end
    if (addr_is(reg_addr, `CFG_EIGHT_ADDR)) begin
      reg_rdata = eight_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // field views of configuration seven
  wire       profile_bit   = seven_r[`PROFILE_BIT];
  wire [3:0] setpoint_code = seven_r[`SETPOINT_HI:`SETPOINT_LO];
  wire       cool_v_bit    = seven_r[`COOL_V_BIT];
  wire       cool_i_bit    = seven_r[`COOL_I_BIT];
  wire       storage_bit   = seven_r[`STORAGE_BIT];

  assign pulse_skip_floor_freq    = six_r[`PFM_HI:`PFM_LO];
  // reserved codes keep the floor on, the safer choice against audible noise
  assign pulse_skip_floor_disable = code_is(six_r[`PFM_HI:`PFM_LO], `PFM_OFF);
  assign settings_unlocked        = unlocked_r;
  assign temp_profile_enable      = profile_bit;
  assign forced_storage_mode      = storage_bit;

  //////////////////////////////////////////////////////////////////////////////
  // temperature profile helper
  thermal_profile u_thermal (
    .core_clk                     (core_clk),
    .rst                          (rst),
    .temp_profile_enable          (profile_bit),
    .junction_regulation_setpoint (setpoint_code),
    .cool_zone_voltage_reduce     (cool_v_bit),
    .cool_zone_current_halve      (cool_i_bit),
    .active_current_code          (active_current_code),
    .junction_temp_c              (junction_temp_c),
    .in_cool_zone                 (in_cool_zone),
    .effective_current_code       (effective_current_code),
    .termination_voltage_reduce   (termination_voltage_reduce),
    .thermal_foldback_flag        (thermal_foldback_flag)
  );

endmodule // charger_config_regs

/* sim/host_model.sv */
// host side of the register interface, one-cycle write strobes
// assumes the bank samples reg_wr on the rising edge
`timescale 1ns/1ps
module host_model (
  input  wire       core_clk,
  output reg  [7:0] reg_addr = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00,
  output reg        reg_wr = 1'b0
);
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= a == 8'h1c ? d & 8'hbf : d; // reserved bit kept zero
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // no stale data once idle
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk) reg_addr <= a;
  endtask
endmodule // host_model

/* sim/charger_config_regs_assertions.sv */
// bound checker on the config bank ports
// assumes one clock and the async high reset
`timescale 1ns/1ps
module cfg_chk (
  input wire       core_clk, rst, reg_wr, cc_reg_protected, watchdog_enabled, in_cool_zone,
  input wire       thermal_foldback_flag, pulse_skip_floor_disable, settings_unlocked,
  input wire       watchdog_restart, charge_current_commit,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata, fast_charge_current_code, junction_temp_c,
  input wire [8:0] active_current_code, effective_current_code,
  input wire [1:0] pulse_skip_floor_freq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire       wr6  = reg_wr && reg_addr == 8'h1c;
  wire       rd7  = reg_addr == 8'h1d && !reg_wr;
  wire       kick = wr6 && reg_wdata[1:0] == 2'h3 && watchdog_enabled;
  wire       key3 = reg_wdata[3:2] == 2'h3;
  wire       half = in_cool_zone && reg_rdata[7] && reg_rdata[1];
  wire [1:0] pfm  = reg_wdata[5:4];
  wire [3:0] sp   = reg_rdata[6:3] > 4'h9 ? 4'h9 : reg_rdata[6:3];
  wire [7:0] lim  = 8'h55 + 8'h05 * sp;
  wire [8:0] act  = active_current_code;
  ////////////////////////////////////////
  a_commit_load: assert property (wr6 && reg_wdata[7] && !cc_reg_protected |=>
    charge_current_commit && act[7:0] == $past(fast_charge_current_code)) else $error("no load");
  a_top_gated: assert property ($changed(act) |-> charge_current_commit) else $error("stray");
  a_key_state: assert property (wr6 |=> settings_unlocked == $past(key3)) else $error("key");
  a_locked_drop: assert property (wr6 && cc_reg_protected && !settings_unlocked |=>
    !charge_current_commit) else $error("locked load");
  a_kick_pulse: assert property (watchdog_restart == $past(kick)) else $error("kick");
  a_pfm_field: assert property (wr6 |=> pulse_skip_floor_freq == $past(pfm)
    && pulse_skip_floor_disable == (pulse_skip_floor_freq == 2'h3)) else $error("floor");
  a_fold_flag: assert property ($past(rd7) |->
    thermal_foldback_flag == ($past(junction_temp_c) > $past(lim))) else $error("foldback");
  a_cool_half: assert property ($past(rd7) |->
    effective_current_code == ($past(half) ? $past(act) >> 1 : $past(act))) else $error("halve");
  cover property (charge_current_commit);
  cover property (watchdog_restart);
  cover property (thermal_foldback_flag && effective_current_code != act);
endmodule // cfg_chk

bind charger_config_regs cfg_chk i_chk (.*);

/* sim/test_charger_config_regs.sv */
// self-checking bench for the charger config bank
// host_model drives the bus, cfg_chk is bound in
`timescale 1ns/1ps
module test_charger_config_regs;
  logic       core_clk = 0, rst = 1, watchdog_enabled = 0, cc_reg_protected = 0, in_cool_zone = 0;
  logic [7:0] fast_charge_current_code = 8'h00, junction_temp_c = 8'h00;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire  [8:0] active_current_code, effective_current_code;
  wire  [1:0] pulse_skip_floor_freq;
  wire        reg_wr, termination_voltage_reduce, thermal_foldback_flag, pulse_skip_floor_disable,
              settings_unlocked, watchdog_restart, charge_current_commit, temp_profile_enable, forced_storage_mode;
  int         err_total = 0, check_count = 0, cyc = 0, act = 0, v, sp;
  always #5 core_clk = ~core_clk;
  charger_config_regs i_dut (.*);
  host_model i_host (.*);
  task chk(input [8:0] s, e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      close_out;
    end
  end
  ////////////////////////////////////////
  initial begin
    v = $urandom(42502);
    repeat (4) @(posedge core_clk);
    rst <= 0;
    i_host.wr(8'h5a, 8'hff);
    i_host.rd(8'h5a);
    #1 chk(reg_rdata, 0);
    i_host.rd(8'h1d);
    #1 chk(reg_rdata, 8'h32);
    chk(settings_unlocked, 0);
    for (int k = 0; k < 4; k++) begin
      i_host.wr(8'h1c, k << 2 | k << 4);
      #1 chk(settings_unlocked, k == 3);
      chk(pulse_skip_floor_disable, k == 3);
    end // ends on the disabled floor, safe for light reverse-buck load
    for (int w = 0; w < 2; w++) begin
      @(posedge core_clk) watchdog_enabled <= w;
      i_host.wr(8'h1c, 8'h3f);
      #1 chk(watchdog_restart, w);
      @(posedge core_clk) #1 chk(watchdog_restart, 0);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk) cc_reg_protected <= i < 2;
      fast_charge_current_code <= $urandom;
      i_host.wr(8'h1c, i == 1 ? 8'h0c : 8'h00);
      i_host.wr(8'h1e, 8'h80);
      #1 chk(active_current_code, act);
      i_host.wr(8'h1c, i == 1 ? 8'h8c : 8'h80);
      if (i > 0) act = 256 + fast_charge_current_code;
      #1 chk(charge_current_commit, i > 0);
      chk(active_current_code, act);
      i_host.rd(8'h1c);
      #1 chk(reg_rdata, i == 1 ? 8'h0c : 8'h00);
    end
    for (int n = 0; n < 24; n++) begin
      v = $urandom;
      sp = v[6:3] > 9 ? 9 : v[6:3];
      i_host.wr(8'h1d, v[7:0]);
      #1 chk(temp_profile_enable, v[7]);
      chk(forced_storage_mode, v[0]);
      @(posedge core_clk) junction_temp_c <= 8'h50 + v[15:10];
      in_cool_zone <= v[9];
      i_host.rd(8'h1d);
      @(posedge core_clk) #1 chk(thermal_foldback_flag, junction_temp_c > 85 + 5 * sp);
      chk(termination_voltage_reduce, v[7] & v[9] & v[2]);
      chk(effective_current_code, v[7] & v[9] & v[1] ? act / 2 : act);
    end
    close_out;
  end
endmodule // test_charger_config_regs
